// ===== rtl/sdram_host_end.sv
// Rules for this block and the memory end
// - Power-up: no-operation, gate and masks high
// - Wait 200 us before first init command
// - Keep byte masks high while waiting
// - Precharge all banks after the wait
// - At least two dummy auto-refreshes next
// - Program mode register last
// - Refresh command with gate low enters self-refresh
// - Memory ignores all but gate after entry
// - Memory self-refreshes while gate stays low
// - Stay in self-refresh at least row-active time
// - Clock stable before raising the gate
// - Gate high at least exit pulse, deselected
// - Wait one row cycle after exit
// - Optional 2048 burst refreshes around self-refresh
// - Gate low suspends internal clock next cycle
// - Full-page burst continues past its length
// - Full-page column counter wraps to zero
// - Precharge ends an ongoing burst
// - Two clocks after mode-register set
// - Row-active time is 42/49/56 ns
`timescale 1ns/10ps
`default_nettype none
module sdram_host_end #(
  parameter int POWER_WAIT = sdram_pkg::POWER_WAIT_CYC,
  parameter int BURST_REF = sdram_pkg::BURST_REF_CNT,
  parameter int REF_INTERVAL = sdram_pkg::REF_INTERVAL_CYC,
  parameter bit BURST_REFRESH = 1'b0,
  parameter logic [2:0] MODE_BL = sdram_pkg::BL_FULL,
  parameter logic [2:0] MODE_CL = sdram_pkg::CL_3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Memory link
  sdram_if.host mem,
  // Access requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [sdram_pkg::BANK_W-1:0] req_bank,
  input wire logic [sdram_pkg::ROW_W-1:0] req_row,
  input wire logic [sdram_pkg::COL_W-1:0] req_col,
  input wire logic [sdram_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  // Read answers
  output logic rd_valid,
  output logic [sdram_pkg::DATA_W-1:0] rd_data,
  // Power control and status
  input wire logic sleep_req,
  output logic sleeping,
  output logic init_done
);
  import sdram_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [3:0] {
    S_PWR, S_IREF, S_MRS, S_IDLE, S_RW, S_RDCAP, S_PRE, S_BREF, S_SRE, S_SR, S_SRX
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [REP_W-1:0] rep;
    logic [3:0] ras;
    logic [CNT_W-1:0] ref_tmr;
    logic post;
    logic init_done;
    logic sleeping;
    cmd_t cmd;
    logic cke;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQM_W-1:0] dqm;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic wr;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] wdata;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
  } host_st_t;

  // Waits hold the count minus one, since a decision lands on the bus an edge later
  localparam logic [CNT_W-1:0] C_RP = 16'(T_RP_CYC - 1);
  localparam logic [CNT_W-1:0] C_RC = 16'(T_RC_CYC - 1);
  localparam logic [CNT_W-1:0] C_RCD = 16'(T_RCD_CYC - 1);
  localparam logic [CNT_W-1:0] C_MRS = 16'(T_MRS_CYC - 1);
  localparam logic [CNT_W-1:0] C_RDL = 16'(T_RDL_CYC - 1);
  localparam logic [CNT_W-1:0] C_SRX = 16'(T_SRX_CYC - 1);
  localparam logic [CNT_W-1:0] C_REF = 16'(REF_INTERVAL - 1);
  localparam logic [3:0] C_RAS = 4'(T_RAS_CYC - 1);
  localparam logic [ADDR_W-1:0] MODE_WORD = 11'({MODE_CL, 1'b0, MODE_BL});
  localparam logic [ADDR_W-1:0] ALL_BANKS = 11'h400;

  host_st_t s_ff;
  host_st_t nxt_s;

  // ==========================================================
  // Sequencer
  always_comb begin
    nxt_s = s_ff;
    req_ready = 1'b0;
    nxt_s.cmd = (s_ff.st == S_SRX) ? CMD_DESEL : CMD_NOP;
    nxt_s.dqm = '1;
    nxt_s.dq_oe = 1'b0;
    nxt_s.rd_valid = 1'b0;
    if (s_ff.ras != '0) begin
      nxt_s.ras = s_ff.ras - 4'h1;
    end
    if (s_ff.ref_tmr != '0) begin
      nxt_s.ref_tmr = s_ff.ref_tmr - 16'h0001;
    end
    if (s_ff.cnt != '0) begin
      nxt_s.cnt = s_ff.cnt - 16'h0001;
    end else begin
      case (s_ff.st)
        S_PWR: begin
          nxt_s.cmd = CMD_PRE;
          nxt_s.addr = ALL_BANKS;
          nxt_s.cnt = C_RP;
          nxt_s.rep = 12'(INIT_REF_CNT);
          nxt_s.st = S_IREF;
        end
        S_IREF: begin
          if (s_ff.rep != '0) begin
            nxt_s.cmd = CMD_REF;
            nxt_s.cnt = C_RC;
            nxt_s.rep = s_ff.rep - 12'h001;
          end else begin
            nxt_s.st = S_MRS;
          end
        end
        S_MRS: begin
          nxt_s.cmd = CMD_MRS;
          nxt_s.addr = MODE_WORD;
          nxt_s.cnt = C_MRS;
          nxt_s.ref_tmr = C_REF;
          nxt_s.init_done = 1'b1;
          nxt_s.st = S_IDLE;
        end
        S_IDLE: begin
          if (s_ff.ref_tmr == '0) begin
            nxt_s.cmd = CMD_REF;
            nxt_s.cnt = C_RC;
            nxt_s.ref_tmr = C_REF;
          end else if (sleep_req) begin
            nxt_s.rep = 12'(BURST_REF);
            nxt_s.post = 1'b0;
            nxt_s.st = BURST_REFRESH ? S_BREF : S_SRE;
          end else if (req_valid) begin
            req_ready = 1'b1;
            nxt_s.cmd = CMD_ACT;
            nxt_s.ba = req_bank;
            nxt_s.addr = req_row;
            nxt_s.wr = req_write;
            nxt_s.col = req_col;
            nxt_s.wdata = req_wdata;
            nxt_s.ras = C_RAS;
            nxt_s.cnt = C_RCD;
            nxt_s.st = S_RW;
          end
        end
        S_RW: begin
          nxt_s.addr = {3'h0, s_ff.col};
          if (s_ff.wr) begin
            // Later full-page words stay masked until the precharge
            nxt_s.cmd = CMD_WR;
            nxt_s.dq = s_ff.wdata;
            nxt_s.dq_oe = 1'b1;
            nxt_s.dqm = '0;
            nxt_s.cnt = C_RDL;
            nxt_s.st = S_PRE;
          end else begin
            nxt_s.cmd = CMD_RD;
            nxt_s.cnt = 16'(MODE_CL);
            nxt_s.st = S_RDCAP;
          end
        end
        S_RDCAP: begin
          nxt_s.rd_valid = 1'b1;
          nxt_s.rd_data = mem.dq;
          nxt_s.st = S_PRE;
        end
        S_PRE: begin
          if (s_ff.ras == '0) begin
            nxt_s.cmd = CMD_PRE;
            nxt_s.addr = '0;
            nxt_s.cnt = C_RP;
            nxt_s.st = S_IDLE;
          end
        end
        S_BREF: begin
          if (s_ff.rep != '0) begin
            nxt_s.cmd = CMD_REF;
            nxt_s.cnt = C_RC;
            nxt_s.rep = s_ff.rep - 12'h001;
          end else if (s_ff.post) begin
            nxt_s.ref_tmr = C_REF;
            nxt_s.st = S_IDLE;
          end else begin
            nxt_s.st = S_SRE;
          end
        end
        S_SRE: begin
          nxt_s.cmd = CMD_REF;
          nxt_s.cke = 1'b0;
          nxt_s.sleeping = 1'b1;
          nxt_s.ras = C_RAS;
          nxt_s.st = S_SR;
        end
        S_SR: begin
          // Clock never stops here, so it is already stable at exit
          if (!sleep_req && s_ff.ras == '0) begin
            nxt_s.cke = 1'b1;
            nxt_s.cmd = CMD_DESEL;
            nxt_s.cnt = (C_RC > C_SRX) ? C_RC : C_SRX;
            nxt_s.st = S_SRX;
          end
        end
        S_SRX: begin
          nxt_s.sleeping = 1'b0;
          nxt_s.rep = 12'(BURST_REF);
          nxt_s.post = 1'b1;
          nxt_s.ref_tmr = C_REF;
          nxt_s.st = BURST_REFRESH ? S_BREF : S_IDLE;
        end
        default: begin
          nxt_s.st = S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.st <= S_PWR;
      s_ff.cnt <= 16'(POWER_WAIT);
      s_ff.cmd <= CMD_NOP;
      s_ff.cke <= 1'b1;
      s_ff.dqm <= '1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs
  assign mem.cs_n = s_ff.cmd[3];
  assign mem.ras_n = s_ff.cmd[2];
  assign mem.cas_n = s_ff.cmd[1];
  assign mem.we_n = s_ff.cmd[0];
  assign mem.cke = s_ff.cke;
  assign mem.ba = s_ff.ba;
  assign mem.addr = s_ff.addr;
  assign mem.dqm = s_ff.dqm;
  assign mem.dq_host = s_ff.dq;
  assign mem.dq_host_oe = s_ff.dq_oe;
  assign rd_valid = s_ff.rd_valid;
  assign rd_data = s_ff.rd_data;
  assign sleeping = s_ff.sleeping;
  assign init_done = s_ff.init_done;

endmodule // sdram_host_end
`default_nettype wire

// ===== rtl/sdram_pkg.sv
package sdram_pkg;

  // ==========================================================
  // Geometry
  localparam int BANK_W = 2;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 32;
  localparam int DQM_W = 4;
  localparam int CNT_W = 16;
  localparam int REP_W = 12;

  // ==========================================================
  // Timing, all at a 200 MHz clock
  localparam int CLK_MHZ = 200;
  localparam int CLK_NS = 5;
  localparam int POWER_WAIT_US = 200;
  localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
  localparam int T_RAS_NS = 42;
  localparam int T_RC_NS = 60;
  localparam int T_RP_NS = 18;
  localparam int T_RCD_NS = 18;
  localparam int T_SRX_NS = 10;
  localparam int T_RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SRX_CYC = (T_SRX_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_MRS_CYC = 2;
  localparam int T_RDL_CYC = 2;
  localparam int INIT_REF_CNT = 2;
  localparam int BURST_REF_CNT = 2048;
  localparam int REF_PERIOD_MS = 64;
  localparam int REF_ROWS = 4096;
  localparam int REF_INTERVAL_CYC = REF_PERIOD_MS * 1000 * CLK_MHZ / REF_ROWS;

  // ==========================================================
  // Commands as {cs_n, ras_n, cas_n, we_n}
  typedef logic [3:0] cmd_t;
  localparam cmd_t CMD_MRS = 4'h0;
  localparam cmd_t CMD_REF = 4'h1;
  localparam cmd_t CMD_PRE = 4'h2;
  localparam cmd_t CMD_ACT = 4'h3;
  localparam cmd_t CMD_WR = 4'h4;
  localparam cmd_t CMD_RD = 4'h5;
  localparam cmd_t CMD_BST = 4'h6;
  localparam cmd_t CMD_NOP = 4'h7;
  localparam cmd_t CMD_DESEL = 4'hF;

  // ==========================================================
  // Mode word fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;

endpackage

// ===== rtl/sdram_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sdram_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [sdram_pkg::BANK_W-1:0] ba;
  logic [sdram_pkg::ADDR_W-1:0] addr;
  logic [sdram_pkg::DQM_W-1:0] dqm;
  logic [sdram_pkg::DATA_W-1:0] dq_host;
  logic dq_host_oe;
  logic [sdram_pkg::DATA_W-1:0] dq_mem;
  logic dq_mem_oe;
  logic [sdram_pkg::DATA_W-1:0] dq;

  // Shared data wire; an undriven bus reads as zero
  assign dq = dq_host_oe ? dq_host : (dq_mem_oe ? dq_mem : '0);

  modport host (
    output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_host, dq_host_oe,
    input dq
  );
  modport mem (
    input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
    output dq_mem, dq_mem_oe
  );
endinterface
`default_nettype wire

// ===== rtl/sdram_mem_end.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_mem_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Memory link
  sdram_if.mem bus,
  // Status
  output logic self_refresh,
  output logic [sdram_pkg::ROW_W-1:0] refresh_row
);
  import sdram_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic cke_q;
    logic sref;
    logic [3:0] open;
    logic [3:0][ROW_W-1:0] row;
    logic [2:0] bl;
    logic [2:0] cl;
    logic burst;
    logic wr;
    logic [BANK_W-1:0] bba;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] left;
    logic [1:0] rv;
    logic [1:0][DATA_W-1:0] rd;
    logic dq_oe;
    logic [DATA_W-1:0] dq;
    logic [ROW_W-1:0] rrow;
    logic [CNT_W-1:0] sr_tmr;
  } mem_st_t;

  localparam int MEM_WORDS = 1 << (BANK_W + ROW_W + COL_W);

  mem_st_t s_ff;
  mem_st_t nxt_s;
  logic [DATA_W-1:0] array [0:MEM_WORDS-1];
  logic go;
  logic wr_en;
  logic [COL_W-1:0] cur_col;
  logic [BANK_W+ROW_W+COL_W-1:0] idx;
  cmd_t cmd;

  // Words left after the first one; full page keeps the whole row as its wrap window
  function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] bl);
    case (bl)
      BL_1: bl_mask = 8'h00;
      BL_2: bl_mask = 8'h01;
      BL_4: bl_mask = 8'h03;
      BL_8: bl_mask = 8'h07;
      default: bl_mask = 8'hFF;
    endcase
  endfunction

  assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};

  // ==========================================================
  // Command decode and burst engine
  always_comb begin
    nxt_s = s_ff;
    nxt_s.cke_q = bus.cke;
    go = 1'b0;
    wr_en = 1'b0;
    cur_col = s_ff.col;
    idx = {s_ff.bba, s_ff.row[s_ff.bba], s_ff.col};
    if (s_ff.sref) begin
      // Only the clock gate is watched; row refresh runs on its own
      if (bus.cke) begin
        nxt_s.sref = 1'b0;
      end
      if (s_ff.sr_tmr == '0) begin
        nxt_s.sr_tmr = 16'(REF_INTERVAL_CYC - 1);
        nxt_s.rrow = s_ff.rrow + 11'h001;
      end else begin
        nxt_s.sr_tmr = s_ff.sr_tmr - 16'h0001;
      end
      nxt_s.dq_oe = 1'b0;
    end else if (s_ff.cke_q) begin
      if (s_ff.burst && (s_ff.left != '0 || s_ff.bl == BL_FULL)) begin
        go = 1'b1;
        cur_col = (s_ff.col & ~bl_mask(s_ff.bl)) |
                  ((s_ff.col + 8'h01) & bl_mask(s_ff.bl));
        nxt_s.left = s_ff.left - 8'h01;
      end else begin
        nxt_s.burst = 1'b0;
      end
      case (cmd)
        CMD_RD, CMD_WR: begin
          if (s_ff.open[bus.ba]) begin
            go = 1'b1;
            cur_col = bus.addr[COL_W-1:0];
            nxt_s.burst = 1'b1;
            nxt_s.wr = (cmd == CMD_WR);
            nxt_s.bba = bus.ba;
            nxt_s.left = bl_mask(s_ff.bl);
          end
        end
        CMD_ACT: begin
          nxt_s.open[bus.ba] = 1'b1;
          nxt_s.row[bus.ba] = bus.addr;
        end
        CMD_PRE: begin
          if (bus.addr[AP_BIT]) begin
            nxt_s.open = 4'h0;
          end else begin
            nxt_s.open[bus.ba] = 1'b0;
          end
          if (bus.addr[AP_BIT] || bus.ba == s_ff.bba) begin
            go = 1'b0;
            nxt_s.burst = 1'b0;
          end
        end
        CMD_BST: begin
          go = 1'b0;
          nxt_s.burst = 1'b0;
        end
        CMD_MRS: begin
          nxt_s.bl = bus.addr[MODE_BL_LSB +: 3];
          nxt_s.cl = bus.addr[MODE_CL_LSB +: 3];
        end
        CMD_REF: begin
          if (!bus.cke) begin
            nxt_s.sref = 1'b1;
            nxt_s.burst = 1'b0;
            nxt_s.sr_tmr = 16'(REF_INTERVAL_CYC - 1);
          end else begin
            nxt_s.rrow = s_ff.rrow + 11'h001;
          end
        end
        default: begin
        end
      endcase
      if (go) begin
        nxt_s.col = cur_col;
      end
      // Word address is built here so that no net feeds back into this process
      idx = {nxt_s.bba, s_ff.row[nxt_s.bba], cur_col};
      wr_en = go && nxt_s.wr;
      // Read pipeline: stage 0 serves latency 2, stage 1 latency 3
      nxt_s.rv[0] = go && !nxt_s.wr;
      nxt_s.rd[0] = array[idx];
      nxt_s.rv[1] = s_ff.rv[0];
      nxt_s.rd[1] = s_ff.rd[0];
      nxt_s.dq_oe = (s_ff.cl == CL_2) ? s_ff.rv[0] : s_ff.rv[1];
      nxt_s.dq = (s_ff.cl == CL_2) ? s_ff.rd[0] : s_ff.rd[1];
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.cke_q <= 1'b1;
      s_ff.cl <= CL_3;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Byte masks gate each lane of a write; no reset on the array itself
  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int b = 0; b < DQM_W; b++) begin
        if (!bus.dqm[b]) begin
          array[idx][b*8 +: 8] <= bus.dq[b*8 +: 8];
        end
      end
    end
  end

  assign bus.dq_mem = s_ff.dq;
  assign bus.dq_mem_oe = s_ff.dq_oe;
  assign self_refresh = s_ff.sref;
  assign refresh_row = s_ff.rrow;

endmodule // sdram_mem_end
`default_nettype wire

// ===== dv/sdram_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_link_checker #(
  parameter int POWER_WAIT = sdram_pkg::POWER_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals driven by the two ends
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdram_pkg::ADDR_W-1:0] addr,
  input wire logic [sdram_pkg::DQM_W-1:0] dqm,
  input wire logic dq_host_oe,
  input wire logic dq_mem_oe
);
  import sdram_pkg::*;

  // ==========================================================
  // Helper state
  typedef struct packed {
    logic [15:0] age;
    logic [2:0] step;
    logic cke_low;
    logic [3:0] exit_left;
  } watch_t;

  watch_t watch_ff;
  watch_t nxt_watch;
  cmd_t cmd;
  logic busy_cmd;

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign busy_cmd = (cmd != CMD_NOP) && (cmd != CMD_DESEL);

  // Exit window counts the rising edge of cke plus eleven more cycles
  always_comb begin
    nxt_watch = watch_ff;
    nxt_watch.cke_low = !cke;
    if (watch_ff.age != 16'hFFFF) nxt_watch.age = watch_ff.age + 16'h1;
    if (busy_cmd && watch_ff.step != 3'h4) nxt_watch.step = watch_ff.step + 3'h1;
    if (cke && watch_ff.cke_low) nxt_watch.exit_left = 4'(T_RC_CYC - 1);
    else if (watch_ff.exit_left != 4'h0) nxt_watch.exit_left = watch_ff.exit_left - 4'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) watch_ff <= '0;
    else watch_ff <= nxt_watch;
  end

  // ==========================================================
  // Assertions
  a_power_up_idle: assert property (@(posedge clk) disable iff (rst)
    (watch_ff.age <= POWER_WAIT) |-> (cmd == CMD_NOP && cke && dqm == 4'hF))
    else $error("link not idle during power-up wait");
  a_init_precharge: assert property (@(posedge clk) disable iff (rst)
    (busy_cmd && watch_ff.step == 3'h0) |-> (cmd == CMD_PRE && addr[AP_BIT]))
    else $error("first command is not precharge all");
  a_init_refresh: assert property (@(posedge clk) disable iff (rst)
    (busy_cmd && (watch_ff.step == 3'h1 || watch_ff.step == 3'h2)) |-> cmd == CMD_REF)
    else $error("init lacks two auto-refreshes");
  a_init_mode_set: assert property (@(posedge clk) disable iff (rst)
    (busy_cmd && watch_ff.step == 3'h3) |-> cmd == CMD_MRS)
    else $error("init does not end with mode set");
  a_init_no_drive: assert property (@(posedge clk) disable iff (rst)
    (watch_ff.step < 3'h4) |-> (!dq_host_oe && !dq_mem_oe))
    else $error("data bus driven during init");
  a_mode_set_gap: assert property (@(posedge clk) disable iff (rst)
    (cmd == CMD_MRS) |=> !busy_cmd)
    else $error("command too soon after mode set");
  a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    $fell(cke) |-> (cmd == CMD_REF))
    else $error("cke dropped without refresh command");
  a_sleep_residency: assert property (@(posedge clk) disable iff (rst)
    (cmd == CMD_REF && !cke) |=> !cke [*8])
    else $error("self-refresh left too early");
  a_exit_deselect: assert property (@(posedge clk) disable iff (rst)
    (cke && (watch_ff.cke_low || watch_ff.exit_left != 4'h0)) |-> cs_n)
    else $error("command during self-refresh exit wait");
  a_sleep_quiet: assert property (@(posedge clk) disable iff (rst)
    !cke |-> (!dq_mem_oe && !dq_host_oe))
    else $error("data bus driven in self-refresh");
  a_pre_ends_burst: assert property (@(posedge clk) disable iff (rst)
    (cmd == CMD_PRE) |-> ##5 !dq_mem_oe)
    else $error("burst continues after precharge");
endmodule // sdram_link_checker
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sdram_pkg::*;
  localparam int POWER_WAIT = 50;
  localparam int BURST_REF = 4;
  localparam int REF_INTERVAL = 200;
  localparam int LIMIT = 9000;

  logic clk, rst, req_valid, req_write, req_ready, rd_valid, sleep_req, sleeping, init_done;
  logic self_refresh;
  logic [BANK_W-1:0] req_bank;
  logic [ROW_W-1:0] req_row, refresh_row, row0;
  logic [COL_W-1:0] req_col;
  logic [DATA_W-1:0] req_wdata, rd_data, word1;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int refs = 0;
  int words = 0;
  int lat;
  cmd_t cmd;

  sdram_if link();
  sdram_host_end #(.POWER_WAIT(POWER_WAIT), .BURST_REF(BURST_REF),
    .REF_INTERVAL(REF_INTERVAL), .BURST_REFRESH(1'b1)) i_sdram_host_end (
    .clk(clk), .rst(rst), .mem(link.host), .req_valid(req_valid), .req_write(req_write),
    .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .sleep_req(sleep_req),
    .sleeping(sleeping), .init_done(init_done));
  sdram_mem_end i_sdram_mem_end (.clk(clk), .rst(rst), .bus(link.mem),
    .self_refresh(self_refresh), .refresh_row(refresh_row));
  sdram_link_checker #(.POWER_WAIT(POWER_WAIT)) i_sdram_link_checker (
    .clk(clk), .rst(rst), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr), .dqm(link.dqm),
    .dq_host_oe(link.dq_host_oe), .dq_mem_oe(link.dq_mem_oe));

  // ==========================================================
  // Clock, link monitor and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

  // Keeps the second word of each read burst to see the column wrap
  always @(posedge clk) begin
    cycles++;
    if (cmd == CMD_REF && link.cke) refs++;
    if (cmd == CMD_RD) words = 0;
    else if (link.dq_mem_oe) begin
      if (words == 1) word1 = link.dq;
      words++;
    end
    if (cycles == LIMIT) begin
      mismatches++;
      $display("timeout after %0d cycles", cycles);
      finish_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_level(ref logic sig, input logic level);
    lat = 0;
    while (sig !== level && lat < 2000) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask

  // Request held until the edge that sees ready high
  task automatic access(input logic wr, input logic [1:0] bank, input logic [10:0] row,
      input logic [7:0] col, input logic [31:0] data);
    // One edge between calls so a release and the next request never share a step
    @(posedge clk);
    #1;
    req_write = wr;
    req_bank = bank;
    req_row = row;
    req_col = col;
    req_wdata = data;
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
  endtask

  task automatic read_word(input string what, input logic [1:0] bank, input logic [10:0] row,
      input logic [7:0] col, input logic [31:0] exp);
    access(1'b0, bank, row, col, 32'h0);
    wait_level(rd_valid, 1'b1);
    check(what, rd_data, exp);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_bank = '0;
    req_row = '0;
    req_col = '0;
    req_wdata = '0;
    sleep_req = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    wait_level(init_done, 1'b1);
    check("init_done", init_done, 1'b1);
    check("init wait length", lat >= POWER_WAIT + 2 * 12, 1'b1);
    $display("test init done");

    access(1'b1, 2'h1, 11'h7FF, 8'hFF, 32'hA5A50FF0);
    access(1'b1, 2'h1, 11'h7FF, 8'h00, 32'h12345678);
    access(1'b1, 2'h2, 11'h000, 8'h05, 32'hDEADBEEF);
    access(1'b1, 2'h2, 11'h000, 8'h06, 32'h0BADF00D);
    access(1'b1, 2'h2, 11'h000, 8'h05, 32'hCAFE0001);
    read_word("bank2 col6 kept", 2'h2, 11'h000, 8'h06, 32'h0BADF00D);
    read_word("bank2 col5 rewritten", 2'h2, 11'h000, 8'h05, 32'hCAFE0001);
    read_word("bank1 col255", 2'h1, 11'h7FF, 8'hFF, 32'hA5A50FF0);
    check("read latency", lat, 32'(1 + T_RCD_CYC + int'(CL_3)));
    repeat (20) @(posedge clk);
    check("burst runs past length", words >= 2, 1'b1);
    check("burst wraps to column 0", word1, 32'h12345678);
    check("precharge stops burst", words <= 8, 1'b1);
    $display("test access done");

    refs = 0;
    repeat (3 * REF_INTERVAL) @(posedge clk);
    check("periodic refresh", refs >= 2, 1'b1);
    $display("test refresh done");

    #1 sleep_req = 1'b1;
    refs = 0;
    wait_level(sleeping, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    check("self-refresh entered", self_refresh, 1'b1);
    check("burst refresh before entry", refs >= BURST_REF, 1'b1);
    row0 = refresh_row;
    repeat (REF_INTERVAL_CYC + 100) @(posedge clk);
    #1;
    check("row pointer moved", refresh_row != row0, 1'b1);
    check("still in self-refresh", self_refresh, 1'b1);
    sleep_req = 1'b0;
    refs = 0;
    wait_level(sleeping, 1'b0);
    check("self-refresh left", self_refresh, 1'b0);
    read_word("data kept through sleep", 2'h2, 11'h000, 8'h06, 32'h0BADF00D);
    check("burst refresh after exit", refs >= BURST_REF, 1'b1);
    $display("test self-refresh done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
